// [core/vpr_resolver.sv]
// vector priority resolver: picks one pending source and forms its fetch address
// assumes request lines and core signals all come from logic on clock
`default_nettype none

module vpr_resolver (
    // clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // request sources
    input wire logic [63:0] src_request,
    input wire logic [127:0] src_level_cfg,
    input wire logic cop_reset_flag,
    // core state
    input wire logic [2:0] core_mask_rank,
    input wire logic [20:0] vector_base_address,
    // core fetch handshake
    input wire logic irq_ack,
    input wire logic entry_valid,
    input wire logic [31:0] entry_data,
    // offered vector
    output logic irq_valid,
    output logic [5:0] irq_vector,
    output logic [2:0] irq_rank,
    output logic [20:0] irq_fetch_addr,
    output logic irq_is_reset,
    // table status
    output logic reset_overlay,
    output logic fetch_busy,
    // resolved handler
    output logic handler_valid,
    output logic [20:0] handler_addr
);

    // per-vector rank and eligibility
    logic [63:0] elig;
    logic [2:0] rank [64];
    logic [63:0] rank_map [vpr_pkg::RANK_NUM];
    logic [vpr_pkg::RANK_NUM-1:0] pick_found;
    logic [5:0] pick_idx [vpr_pkg::RANK_NUM];

    genvar gv;
    genvar gr;

    generate
        for (gv = 0; gv < 64; gv++) begin : g_vec
            logic [1:0] cfg;
            logic raw;
            logic fixed_exc;
            assign cfg = src_level_cfg[2*gv +: 2];
            if (gv == vpr_pkg::VEC_CHIP_RESET || gv == vpr_pkg::VEC_COP_RESET) begin : g_rst
                // reset slots are served only by the boot sequence
                assign raw = 1'b0;
                assign rank[gv] = vpr_pkg::RANK_LVL3;
                assign fixed_exc = 1'b0;
            end else if (vpr_pkg::VEC_RESERVED_MAP[gv]) begin : g_rsv
                assign raw = 1'b0;
                assign rank[gv] = vpr_pkg::RANK_LVL_LOW;
                assign fixed_exc = 1'b0;
            end else if (gv <= vpr_pkg::VEC_EXC_LAST) begin : g_exc
                assign raw = src_request[gv];
                assign rank[gv] = vpr_pkg::RANK_LVL3;
                assign fixed_exc = 1'b1;
            end else if (gv <= vpr_pkg::VEC_DBG_LAST || gv == vpr_pkg::VEC_LVD
                    || gv == vpr_pkg::VEC_PLL) begin : g_p13
                // code n selects level n, code 0 switches the source off
                assign raw = src_request[gv] && (cfg != vpr_pkg::LVL_CFG_OFF);
                assign rank[gv] = {1'b0, cfg} + 3'h1;
                assign fixed_exc = 1'b0;
            end else if (gv == vpr_pkg::VEC_SWI2) begin : g_sw2
                assign raw = src_request[gv];
                assign rank[gv] = vpr_pkg::RANK_LVL2;
                assign fixed_exc = 1'b0;
            end else if (gv == vpr_pkg::VEC_SWI1) begin : g_sw1
                assign raw = src_request[gv];
                assign rank[gv] = vpr_pkg::RANK_LVL1;
                assign fixed_exc = 1'b0;
            end else if (gv == vpr_pkg::VEC_SWI0) begin : g_sw0
                assign raw = src_request[gv];
                assign rank[gv] = vpr_pkg::RANK_LVL0;
                assign fixed_exc = 1'b0;
            end else if (gv <= vpr_pkg::VEC_PERIPH_LAST) begin : g_p02
                // code n selects level n-1, code 0 switches the source off
                assign raw = src_request[gv] && (cfg != vpr_pkg::LVL_CFG_OFF);
                assign rank[gv] = {1'b0, cfg};
                assign fixed_exc = 1'b0;
            end else begin : g_low
                assign raw = src_request[gv];
                assign rank[gv] = vpr_pkg::RANK_LVL_LOW;
                assign fixed_exc = 1'b0;
            end
            // masked sources drop out before the pickers; fixed exceptions bypass the mask
            assign elig[gv] = raw && (fixed_exc || (rank[gv] >= core_mask_rank));
        end

        for (gr = 0; gr < vpr_pkg::RANK_NUM; gr++) begin : g_rank
            for (gv = 0; gv < 64; gv++) begin : g_bit
                assign rank_map[gr][gv] = elig[gv] && (rank[gv] == 3'(gr));
            end
            vpr_level_pick u_pick (
                .rank_map(rank_map[gr]),
                .found(pick_found[gr]),
                .index(pick_idx[gr])
            );
        end
    endgenerate

    // winner across ranks
    logic win_found;
    logic [5:0] win_vec;
    logic [2:0] win_rank;

    always_comb begin
        win_found = 1'b0;
        win_vec = 6'h00;
        win_rank = vpr_pkg::RANK_LVL_LOW;
        // ascending walk: the highest rank with a request writes last
        for (int r = 0; r < vpr_pkg::RANK_NUM; r++) begin
            if (pick_found[r]) begin
                win_found = 1'b1;
                win_vec = pick_idx[r];
                win_rank = r[2:0];
            end
        end
    end

    // table address of the winner
    logic [20:0] win_offset;
    logic [20:0] win_addr;
    logic [20:0] boot_addr;

    assign win_offset = {15'h0000, win_vec} << vpr_pkg::ENTRY_SHIFT;
    // the sum wraps at the top of the 21-bit program space
    assign win_addr = 21'(vector_base_address + win_offset);

    // control state
    vpr_pkg::vpr_state_t state_q;
    vpr_pkg::vpr_state_t state_d;
    logic cop_boot_q;
    logic cop_boot_d;
    logic [5:0] vec_q;
    logic [5:0] vec_d;
    logic [2:0] rank_q;
    logic [2:0] rank_d;
    logic [20:0] addr_q;
    logic [20:0] addr_d;
    logic is_reset_q;
    logic is_reset_d;
    logic overlay_q;
    logic overlay_d;
    logic hvalid_q;
    logic hvalid_d;
    logic [20:0] haddr_q;
    logic [20:0] haddr_d;

    // reset fetch locations are fixed; they match the table only at the reset base
    assign boot_addr = cop_boot_q ? 21'(vpr_pkg::BASE_RESET + vpr_pkg::COP_RESET_OFFSET)
                                  : vpr_pkg::BASE_RESET;

    always_comb begin
        state_d = state_q;
        cop_boot_d = cop_boot_q;
        vec_d = vec_q;
        rank_d = rank_q;
        addr_d = addr_q;
        is_reset_d = is_reset_q;
        unique case (state_q)
            vpr_pkg::VPR_ST_STRAP: begin
                // catch the watchdog cause in the first cycle after release
                cop_boot_d = cop_reset_flag;
                state_d = vpr_pkg::VPR_ST_BOOT;
            end
            vpr_pkg::VPR_ST_BOOT: begin
                // reset offers carry the fixed reset fetch locations, not the table
                vec_d = cop_boot_q ? 6'(vpr_pkg::VEC_COP_RESET)
                                   : 6'(vpr_pkg::VEC_CHIP_RESET);
                rank_d = vpr_pkg::RANK_LVL3;
                addr_d = boot_addr;
                is_reset_d = 1'b1;
                if (irq_ack && is_reset_q) begin
                    state_d = vpr_pkg::VPR_ST_FETCH;
                end
            end
            vpr_pkg::VPR_ST_IDLE: begin
                is_reset_d = 1'b0;
                if (win_found) begin
                    vec_d = win_vec;
                    rank_d = win_rank;
                    addr_d = win_addr;
                    state_d = vpr_pkg::VPR_ST_OFFER;
                end
            end
            vpr_pkg::VPR_ST_OFFER: begin
                if (irq_ack) begin
                    // the core takes whatever is shown at the ack edge
                    state_d = vpr_pkg::VPR_ST_FETCH;
                end else if (!win_found) begin
                    // source withdrew or was masked before the core took it
                    state_d = vpr_pkg::VPR_ST_IDLE;
                end else begin
                    // a better source may displace the one on offer
                    vec_d = win_vec;
                    rank_d = win_rank;
                    addr_d = win_addr;
                end
            end
            vpr_pkg::VPR_ST_FETCH: begin
                // the core may take any number of cycles to return the entry
                if (entry_valid) begin
                    state_d = vpr_pkg::VPR_ST_GAP;
                end
            end
            vpr_pkg::VPR_ST_GAP: begin
                // one idle cycle lets the served source drop its line
                is_reset_d = 1'b0;
                state_d = vpr_pkg::VPR_ST_IDLE;
            end
            default: begin
                state_d = vpr_pkg::VPR_ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            state_q <= vpr_pkg::VPR_ST_STRAP;
            cop_boot_q <= 1'b0;
            vec_q <= 6'h00;
            rank_q <= vpr_pkg::RANK_LVL_LOW;
            addr_q <= vpr_pkg::BASE_RESET;
            is_reset_q <= 1'b0;
        end else begin
            state_q <= state_d;
            cop_boot_q <= cop_boot_d;
            vec_q <= vec_d;
            rank_q <= rank_d;
            addr_q <= addr_d;
            is_reset_q <= is_reset_d;
        end
    end

    // handler capture: low entry bits are the target, upper address bits read zero
    always_comb begin
        hvalid_d = 1'b0;
        haddr_d = haddr_q;
        if (state_q == vpr_pkg::VPR_ST_FETCH && entry_valid) begin
            hvalid_d = 1'b1;
            haddr_d = {2'b00, entry_data[vpr_pkg::TARGET_W-1:0]};
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            hvalid_q <= 1'b0;
            haddr_q <= 21'h000000;
        end else begin
            hvalid_q <= hvalid_d;
            haddr_q <= haddr_d;
        end
    end

    // overlay status trails the base by one cycle
    always_comb begin
        overlay_d = (vector_base_address == vpr_pkg::BASE_RESET);
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            overlay_q <= 1'b0;
        end else begin
            overlay_q <= overlay_d;
        end
    end

    // outputs
    // the boot offer waits one cycle for its vector and address to load
    assign irq_valid = (state_q == vpr_pkg::VPR_ST_OFFER)
                    || (state_q == vpr_pkg::VPR_ST_BOOT && is_reset_q);
    assign irq_vector = vec_q;
    assign irq_rank = rank_q;
    assign irq_fetch_addr = addr_q;
    assign irq_is_reset = is_reset_q;
    assign reset_overlay = overlay_q;
    assign fetch_busy = (state_q == vpr_pkg::VPR_ST_FETCH);
    assign handler_valid = hvalid_q;
    assign handler_addr = haddr_q;

endmodule : vpr_resolver

`default_nettype wire

// [inc/vpr_pkg.sv]
// vector priority resolver: shared constants, vector classes and state type
// assumes one system clock and a synchronous active-low chip reset
`default_nettype none

package vpr_pkg;

    // table geometry
    localparam int unsigned VEC_NUM = 64;
    localparam int unsigned VEC_W = 6;
    localparam int unsigned PADDR_W = 21;
    localparam int unsigned TARGET_W = 19;
    localparam int unsigned ENTRY_W = 32;
    localparam int unsigned LVL_CFG_W = 2;
    localparam int unsigned RANK_W = 3;
    localparam int unsigned RANK_NUM = 5;

    // vector base after reset, also the boot fetch location
    localparam logic [20:0] BASE_RESET = 21'h000000;
    // entry offset is vector shifted by one: two program words per entry
    localparam int unsigned ENTRY_SHIFT = 1;
    localparam logic [20:0] COP_RESET_OFFSET = 21'h000002;

    // vector numbers
    localparam int unsigned VEC_CHIP_RESET = 0;
    localparam int unsigned VEC_COP_RESET = 1;
    localparam int unsigned VEC_EXC_FIRST = 2;
    localparam int unsigned VEC_EXC_LAST = 5;
    localparam int unsigned VEC_DBG_FIRST = 6;
    localparam int unsigned VEC_DBG_LAST = 10;
    localparam int unsigned VEC_SWI2 = 11;
    localparam int unsigned VEC_SWI1 = 12;
    localparam int unsigned VEC_SWI0 = 13;
    localparam int unsigned VEC_LVD = 15;
    localparam int unsigned VEC_PLL = 16;
    localparam int unsigned VEC_PERIPH_FIRST = 17;
    localparam int unsigned VEC_PERIPH_LAST = 62;
    localparam int unsigned VEC_SOFT_LOW = 63;

    // slots that never raise a request
    localparam logic [63:0] VEC_RESERVED_MAP = 64'h031E_00F0_C0F0_4000;

    // ranks: level -1 is rank 0, level n is rank n+1
    localparam logic [2:0] RANK_LVL_LOW = 3'h0;
    localparam logic [2:0] RANK_LVL0 = 3'h1;
    localparam logic [2:0] RANK_LVL1 = 3'h2;
    localparam logic [2:0] RANK_LVL2 = 3'h3;
    localparam logic [2:0] RANK_LVL3 = 3'h4;

    // level code that switches a programmable source off
    localparam logic [1:0] LVL_CFG_OFF = 2'h0;

    typedef enum logic [2:0] {
        VPR_ST_STRAP,
        VPR_ST_BOOT,
        VPR_ST_IDLE,
        VPR_ST_OFFER,
        VPR_ST_FETCH,
        VPR_ST_GAP
    } vpr_state_t;

endpackage : vpr_pkg

`default_nettype wire

// [core/vpr_level_pick.sv]
// lowest-index finder over one priority rank's request map
// assumes a plain combinational map from the same clock domain
`default_nettype none

module vpr_level_pick (
    // requests of one rank
    input wire logic [63:0] rank_map,
    // result
    output logic found,
    output logic [5:0] index
);

    always_comb begin
        found = 1'b0;
        index = 6'h00;
        // walk downward so the smallest vector is the last to write
        for (int v = 63; v >= 0; v--) begin
            if (rank_map[v]) begin
                found = 1'b1;
                index = v[5:0];
            end
        end
    end

endmodule : vpr_level_pick

`default_nettype wire

// [bench/vpr_resolver_props.sv]
// checker on the resolver ports
// assumes one clock and a synchronous active-low reset
`default_nettype none
module vpr_resolver_props (
    // clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // inputs
    input wire logic [2:0] core_mask_rank,
    input wire logic [20:0] vector_base_address,
    input wire logic irq_ack,
    input wire logic entry_valid,
    input wire logic [31:0] entry_data,
    // outputs
    input wire logic irq_valid,
    input wire logic [5:0] irq_vector,
    input wire logic [2:0] irq_rank,
    input wire logic [20:0] irq_fetch_addr,
    input wire logic irq_is_reset,
    input wire logic reset_overlay,
    input wire logic fetch_busy,
    input wire logic handler_valid,
    input wire logic [20:0] handler_addr
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_n);
    a_entry_offset: assert property (irq_valid && !irq_is_reset && $stable(vector_base_address)
        |-> irq_fetch_addr == vector_base_address + 21'({irq_vector, 1'b0}))
        else $error("fetch address off");
    a_reset_slot: assert property (irq_valid && irq_is_reset
        |-> irq_vector < 6'h02 && irq_fetch_addr == vpr_pkg::BASE_RESET + 21'({irq_vector, 1'b0}))
        else $error("reset offer wrong");
    a_handler_cut: assert property (fetch_busy && entry_valid
        |=> handler_valid && handler_addr == 21'($past(entry_data) & 32'h0007_FFFF))
        else $error("handler target wrong");
    a_exc_rank: assert property (irq_valid && irq_vector inside {[6'h02:6'h05]}
        |-> irq_rank == 3'h4)
        else $error("exception rank wrong");
    a_dbg_rank: assert property (irq_valid && irq_vector inside {[6'h06:6'h0A], 6'h0F, 6'h10}
        |-> irq_rank >= 3'h2)
        else $error("level below one");
    a_periph_rank: assert property (irq_valid && irq_vector inside {[6'h11:6'h3E]}
        |-> irq_rank inside {[3'h1:3'h3]})
        else $error("peripheral rank wrong");
    a_low_soft: assert property (irq_valid && irq_vector == 6'h3F |-> irq_rank == 3'h0)
        else $error("low soft rank wrong");
    a_mask_pass: assert property (irq_valid && irq_vector > 6'h05 && $stable(core_mask_rank)
        |-> irq_rank >= core_mask_rank)
        else $error("masked source offered");
    a_reserved_quiet: assert property (irq_valid |-> !vpr_pkg::VEC_RESERVED_MAP[irq_vector])
        else $error("reserved slot offered");
    a_overlay_flag: assert property ($past(rst_n)
        |-> reset_overlay == ($past(vector_base_address) == vpr_pkg::BASE_RESET))
        else $error("overlay flag wrong");
    a_ack_fetch: assert property (irq_valid && irq_ack |=> fetch_busy && !irq_valid)
        else $error("taken offer did not start fetch");
    a_handler_pulse: assert property (handler_valid |=> !handler_valid)
        else $error("handler valid held");
    c_cop_boot: cover property (irq_valid && irq_is_reset && irq_vector == 6'h01);
    c_top_taken: cover property (irq_valid && irq_ack && irq_rank == 3'h4);
    c_preempt: cover property (irq_valid && $past(irq_valid) && $changed(irq_vector));
endmodule : vpr_resolver_props
bind vpr_resolver vpr_resolver_props vpr_resolver_props_inst (.clock, .rst_n,
    .core_mask_rank, .vector_base_address, .irq_ack, .entry_valid, .entry_data,
    .irq_valid, .irq_vector, .irq_rank, .irq_fetch_addr, .irq_is_reset,
    .reset_overlay, .fetch_busy, .handler_valid, .handler_addr);
`default_nettype wire

// [bench/vpr_core_model.sv]
// core model: takes offers, returns table entries after a set delay
// assumes the resolver fetch handshake on the same clock
`default_nettype none
module vpr_core_model (
    // clock, reset and bench control
    input wire logic clock,
    input wire logic rst_n,
    input wire logic ack_en,
    input wire logic [3:0] entry_delay,
    // resolver side
    input wire logic irq_valid,
    input wire logic [20:0] irq_fetch_addr,
    input wire logic fetch_busy,
    output logic irq_ack,
    output logic entry_valid,
    output logic [31:0] entry_data
);
    logic [20:0] taken_q;
    logic [3:0] wait_q;
    logic [31:0] word;
    // high bits set so the 19-bit target limit shows
    assign word = {8'hA5, 5'h1F, taken_q[18:0]};
    // idle data lines show the inverse, never the last word
    assign entry_data = entry_valid ? word : ~word;
    always @(posedge clock) begin
        if (!rst_n) begin
            irq_ack <= 1'b0;
            entry_valid <= 1'b0;
            taken_q <= 21'h000000;
        end else begin
            irq_ack <= ack_en && irq_valid && !irq_ack;
            entry_valid <= 1'b0;
            if (irq_ack && irq_valid) begin
                taken_q <= irq_fetch_addr;
                wait_q <= entry_delay;
            end else if (fetch_busy && !entry_valid) begin
                if (wait_q == 4'h0) begin
                    entry_valid <= 1'b1;
                end else begin
                    wait_q <= wait_q - 4'h1;
                end
            end
        end
    end
endmodule : vpr_core_model
`default_nettype wire

// [bench/vector_priority_resolver_tb_top.sv]
// bench: raises requests, checks offers and handler targets
// assumes package, resolver, core model and checker compiled first
`default_nettype none
module vector_priority_resolver_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock, rst_n, cop_reset_flag, ack_en, irq_ack, entry_valid;
    logic irq_valid, irq_is_reset, reset_overlay, fetch_busy, handler_valid;
    logic [63:0] src_request;
    logic [127:0] src_level_cfg;
    logic [2:0] core_mask_rank, irq_rank;
    logic [20:0] vector_base_address, irq_fetch_addr, handler_addr;
    logic [5:0] irq_vector;
    logic [31:0] entry_data;
    logic [3:0] entry_delay;
    int n_mismatch = 0;
    int check_count = 0;
    vpr_resolver vpr_resolver_inst (.clock, .rst_n, .src_request, .src_level_cfg,
        .cop_reset_flag, .core_mask_rank, .vector_base_address, .irq_ack, .entry_valid,
        .entry_data, .irq_valid, .irq_vector, .irq_rank, .irq_fetch_addr, .irq_is_reset,
        .reset_overlay, .fetch_busy, .handler_valid, .handler_addr);
    vpr_core_model vpr_core_model_inst (.clock, .rst_n, .ack_en, .entry_delay,
        .irq_valid, .irq_fetch_addr, .fetch_busy, .irq_ack, .entry_valid, .entry_data);
    initial begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end
    task finish_test;
        if (n_mismatch == 0 && check_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : finish_test
    task chk(input logic [20:0] got, input logic [20:0] exp);
        check_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task step(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask : step
    task req(input int v, input logic [1:0] code);
        src_level_cfg[2*v +: 2] = code;
        src_request[v] = 1'b1;
    endtask : req
    // rank 7 marks a boot offer: fixed address, rank not checked
    task serve(input logic [5:0] v, input logic [2:0] r);
        logic [20:0] a;
        int i;
        a = (r == 3'h7) ? vpr_pkg::BASE_RESET : vector_base_address;
        a = a + 21'({v, 1'b0});
        for (i = 0; i < 40 && irq_valid !== 1'b1; i++) step(1);
        step(2);
        chk(21'(irq_vector), 21'(v));
        if (r != 3'h7) chk(21'(irq_rank), 21'(r));
        chk(irq_fetch_addr, a);
        chk(21'(irq_is_reset), 21'(r == 3'h7));
        ack_en = 1'b1;
        for (i = 0; i < 40 && handler_valid !== 1'b1; i++) step(1);
        chk(21'(handler_valid), 21'h000001);
        chk(handler_addr, {2'h0, a[18:0]});
        src_request[v] = 1'b0;
        ack_en = 1'b0;
    endtask : serve
    task t_boot(input logic cop, input logic [20:0] base);
        cop_reset_flag = cop;
        vector_base_address = base;
        rst_n = 1'b0;
        step(8);
        chk(21'({irq_valid, irq_is_reset, handler_valid}), 21'h000000);
        chk(irq_fetch_addr, vpr_pkg::BASE_RESET);
        rst_n = 1'b1;
        serve({5'h00, cop}, 3'h7);
        chk(21'(reset_overlay), 21'(base == vpr_pkg::BASE_RESET));
    endtask : t_boot
    task t_levels;
        vector_base_address = 21'h001000;
        req(63, 2'h0);
        step(4);
        chk(21'(irq_vector), 21'h00003F);
        req(45, 2'h3);
        req(6, 2'h1);
        req(13, 2'h0);
        req(24, 2'h1);
        req(12, 2'h3);
        serve(6'h2D, 3'h3);
        serve(6'h06, 3'h2);
        serve(6'h0C, 3'h2);
        serve(6'h0D, 3'h1);
        serve(6'h18, 3'h1);
        serve(6'h3F, 3'h0);
    endtask : t_levels
    task t_ties;
        req(16, 2'h3);
        req(15, 2'h1);
        req(17, 2'h2);
        req(33, 2'h2);
        req(20, 2'h3);
        req(14, 2'h3);
        req(7, 2'h0);
        req(8, 2'h2);
        serve(6'h10, 3'h4);
        serve(6'h08, 3'h3);
        serve(6'h0F, 3'h2);
        serve(6'h11, 3'h2);
        serve(6'h21, 3'h2);
        step(6);
        chk(21'(irq_valid), 21'h000000);
        src_request = 64'h0;
    endtask : t_ties
    task t_mask;
        vector_base_address = 21'h1FFF00;
        entry_delay = 4'h5;
        core_mask_rank = 3'h4;
        req(3, 2'h0);
        req(5, 2'h0);
        req(10, 2'h3);
        req(62, 2'h3);
        req(11, 2'h0);
        req(40, 2'h0);
        serve(6'h03, 3'h4);
        serve(6'h05, 3'h4);
        serve(6'h0A, 3'h4);
        step(6);
        chk(21'(irq_valid), 21'h000000);
        core_mask_rank = 3'h7;
        req(2, 2'h0);
        serve(6'h02, 3'h4);
        core_mask_rank = 3'h0;
        serve(6'h0B, 3'h3);
        serve(6'h3E, 3'h3);
        step(6);
        chk(21'(irq_valid), 21'h000000);
    endtask : t_mask
    initial begin
        ack_en = 1'b0;
        entry_delay = 4'h0;
        src_request = 64'h0;
        src_level_cfg = 128'h0;
        core_mask_rank = 3'h0;
        t_boot(1'b0, 21'h000000);
        t_boot(1'b1, 21'h001000);
        t_levels;
        t_ties;
        t_mask;
        finish_test;
    end
    initial begin
        #400000;
        n_mismatch++;
        finish_test;
    end
endmodule : vector_priority_resolver_tb_top
`default_nettype wire
